// >>> irq_cpu_ctrl.sv
// CPU-side controller: AHB-Lite registers that drive the link.
`timescale 1ns/10ps
module irq_cpu_ctrl
  import irq_flag_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // transfer size, word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready, always high
  output logic hresp, // response, always OKAY
  output logic [31:0] hrdata, // read data
  irq_link_if.host link // device side
);

  // ************************************************************
  // Bus slave
  // ************************************************************

  logic ap_q;
  logic ap_wr_q;
  logic [31:0] ap_addr_q;
  logic wr_cmd;
  logic wr_ctrl;
  host_state_t st_q;
  logic [15:0] cmd_addr_q;
  logic [3:0] cmd_data_q;
  logic cmd_we_q;
  logic sel_q;
  logic [3:0] rd_q;
  logic iflag_q;
  logic [CTRL_PULSES-1:0] pulse_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      ap_wr_q <= 1'b0;
      ap_addr_q <= 32'h0000_0000;
    end else if (ce && hready) begin
      ap_q <= hsel && htrans[1];
      ap_wr_q <= hwrite;
      ap_addr_q <= haddr;
    end
  end

  assign wr_cmd = ce && ap_q && ap_wr_q && ap_addr_q == HOST_CMD_OFS;
  assign wr_ctrl = ce && ap_q && ap_wr_q && ap_addr_q == HOST_CTRL_OFS;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    hrdata = 32'h0000_0000;
    case (ap_addr_q)
      HOST_CMD_OFS: begin
        hrdata[15:0] = cmd_addr_q;
        hrdata[CMD_DATA_LSB+:4] = cmd_data_q;
        hrdata[CMD_WRITE_BIT] = cmd_we_q;
      end
      HOST_STAT_OFS: begin
        hrdata[STAT_BUSY_BIT] = st_q == H_WAIT;
        hrdata[STAT_RDATA_LSB+:4] = rd_q;
        hrdata[STAT_IRQ_BIT] = link.irq_req;
        hrdata[STAT_NMI_BIT] = link.nmi_req;
      end
      HOST_CTRL_OFS: hrdata[CTRL_IFLAG_BIT] = iflag_q;
      default: hrdata = 32'h0000_0000;
    endcase
  end

  // ************************************************************
  // Link access sequencer
  // ************************************************************

  // A command written while busy is dropped; poll the busy bit.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= H_IDLE;
      sel_q <= 1'b0;
      cmd_addr_q <= 16'h0000;
      cmd_data_q <= 4'h0;
      cmd_we_q <= 1'b0;
      rd_q <= 4'h0;
    end else if (ce) begin
      sel_q <= 1'b0;
      case (st_q)
        H_IDLE: begin
          if (wr_cmd) begin
            cmd_addr_q <= hwdata[15:0];
            cmd_data_q <= hwdata[CMD_DATA_LSB+:4];
            cmd_we_q <= hwdata[CMD_WRITE_BIT];
            sel_q <= 1'b1;
            st_q <= H_WAIT;
          end
        end
        H_WAIT: begin
          if (link.ack) begin
            if (!cmd_we_q) begin
              rd_q <= link.rdata;
            end
            st_q <= H_IDLE;
          end
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  // Writing one to a pulse bit makes a one-cycle strobe.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iflag_q <= 1'b0;
      pulse_q <= '0;
    end else if (ce) begin
      pulse_q <= wr_ctrl ? hwdata[CTRL_PULSE_LSB+:CTRL_PULSES] : '0;
      if (wr_ctrl) begin
        iflag_q <= hwdata[CTRL_IFLAG_BIT];
      end
    end
  end

  assign link.sel = sel_q;
  assign link.we = cmd_we_q;
  assign link.addr = cmd_addr_q;
  assign link.wdata = cmd_data_q;
  assign link.iflag = iflag_q;
  assign link.int_return = pulse_q[0];
  assign link.ptr1_wr = pulse_q[1];
  assign link.ptr2_wr = pulse_q[2];
  assign link.int_ack = pulse_q[3];
  assign link.nmi_ack = pulse_q[4];
  assign link.sleep = pulse_q[5];

endmodule

// >>> irq_flag_group.sv
// One four-bit group of source flags with its mask word.
`timescale 1ns/10ps
module irq_flag_group
  import irq_flag_pkg::*;
#(
  parameter logic [3:0] IMPL = 4'hf
) (
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic ce, // clock enable
  input wire logic [3:0] event_in, // event pulses per bit
  input wire logic flag_wr, // write strobe to the flag word
  input wire logic mask_wr, // write strobe to the mask word
  input wire logic [3:0] wdata, // write data
  output logic [3:0] flag_q, // source flags
  output logic [3:0] mask_q, // mask bits
  output logic [3:0] pend // flags that pass their mask
);
  logic [3:0] clr;

  assign clr = flag_wr ? wdata : 4'h0;
  assign pend = flag_q & mask_q;

  // Set outranks a clear in the same cycle, so no event is lost.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= FLAG_RST;
    end else if (ce) begin
      flag_q <= ((flag_q & ~clr) | event_in) & IMPL;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mask_q <= MASK_RST;
    end else if (ce && mask_wr) begin
      mask_q <= wdata & IMPL;
    end
  end
endmodule

// >>> irq_flag_pkg.sv
// Shared constants and types for the interrupt flag and mask unit.
package irq_flag_pkg;
  localparam int GROUPS = 11;
  localparam int PERIPH_GROUPS = 9;
  localparam int DW = 4;
  localparam int AW = 16;
  localparam int G_KEY0 = 6;
  localparam int G_KEY1 = 7;
  localparam int G_FAST_CLK = 9;
  localparam int G_SLOW_CLK = 10;
  localparam logic [3:0] FLAG_RST = 4'h0;
  localparam logic [3:0] MASK_RST = 4'h0;
  localparam logic [15:0] MASK_CONV_OFS = 16'hffe1;
  localparam logic [15:0] MASK_TMR0_OFS = 16'hffe2;
  localparam logic [15:0] MASK_TMR1_OFS = 16'hffe3;
  localparam logic [15:0] MASK_TMR2_OFS = 16'hffe4;
  localparam logic [15:0] MASK_TMR3_OFS = 16'hffe5;
  localparam logic [15:0] MASK_SER_OFS = 16'hffea;
  localparam logic [15:0] MASK_KEY0_OFS = 16'hffeb;
  localparam logic [15:0] MASK_KEY1_OFS = 16'hffec;
  localparam logic [15:0] MASK_SW_OFS = 16'hffed;
  localparam logic [15:0] MASK_FAST_OFS = 16'hffee;
  localparam logic [15:0] MASK_SLOW_OFS = 16'hffef;
  localparam logic [15:0] FLAG_CONV_OFS = 16'hfff1;
  localparam logic [15:0] FLAG_TMR0_OFS = 16'hfff2;
  localparam logic [15:0] FLAG_TMR1_OFS = 16'hfff3;
  localparam logic [15:0] FLAG_TMR2_OFS = 16'hfff4;
  localparam logic [15:0] FLAG_TMR3_OFS = 16'hfff5;
  localparam logic [15:0] FLAG_SER_OFS = 16'hfffa;
  localparam logic [15:0] FLAG_KEY0_OFS = 16'hfffb;
  localparam logic [15:0] FLAG_KEY1_OFS = 16'hfffc;
  localparam logic [15:0] FLAG_SW_OFS = 16'hfffd;
  localparam logic [15:0] FLAG_FAST_OFS = 16'hfffe;
  localparam logic [15:0] FLAG_SLOW_OFS = 16'hffff;
  localparam logic [15:0] MASK_OFS [GROUPS] = '{MASK_CONV_OFS,
    MASK_TMR0_OFS, MASK_TMR1_OFS, MASK_TMR2_OFS, MASK_TMR3_OFS,
    MASK_SER_OFS, MASK_KEY0_OFS, MASK_KEY1_OFS, MASK_SW_OFS,
    MASK_FAST_OFS, MASK_SLOW_OFS};
  localparam logic [15:0] FLAG_OFS [GROUPS] = '{FLAG_CONV_OFS,
    FLAG_TMR0_OFS, FLAG_TMR1_OFS, FLAG_TMR2_OFS, FLAG_TMR3_OFS,
    FLAG_SER_OFS, FLAG_KEY0_OFS, FLAG_KEY1_OFS, FLAG_SW_OFS,
    FLAG_FAST_OFS, FLAG_SLOW_OFS};
  localparam logic [3:0] IMPL_BITS [GROUPS] = '{4'h7, 4'h3, 4'h3,
    4'h3, 4'h3, 4'h1, 4'hf, 4'hf, 4'hf, 4'hf, 4'hf};
  localparam logic [31:0] HOST_CMD_OFS = 32'h0000_0000;
  localparam logic [31:0] HOST_STAT_OFS = 32'h0000_0004;
  localparam logic [31:0] HOST_CTRL_OFS = 32'h0000_0008;
  localparam int CMD_DATA_LSB = 16;
  localparam int CMD_WRITE_BIT = 24;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_RDATA_LSB = 4;
  localparam int STAT_IRQ_BIT = 8;
  localparam int STAT_NMI_BIT = 9;
  localparam int CTRL_IFLAG_BIT = 0;
  localparam int CTRL_PULSE_LSB = 1;
  localparam int CTRL_PULSES = 6;
  typedef enum logic [1:0] {SP_NONE, SP_FIRST, SP_SECOND, SP_BOTH} sp_state_t;
  typedef enum logic {H_IDLE, H_WAIT} host_state_t;
endpackage

// >>> irq_flag_unit.sv
// Interrupt flag and mask unit, the device end of the link.
//
// Behaviour
// - Mask bits are read and write storage
// - Set flag with set mask raises request
// - Reset clears all mask bits
// - Events set flags whatever the mask
// - Flag reads show event since last clear
// - Writing one clears a flag, zero ignored
// - Reset clears all source flags
// - Taken request repeats after enable or return
// - Handler clears its flag before re-enabling
// - All requests blocked until both stack pointers
// - One pointer written blocks until the other
// - Handlers lie near the vector range
// - Converter events map to bits 2..0
// - Timer underflow bit 1, match bit 0
// - Serial completion sets serial bit 0
// - Key lines set key port words
// - Stopwatch events set stopwatch word bits
// - Fast clock taps fall to set flags
// - Slow clock taps fall to set flags
// - Sleep stops both oscillators
// - Software selects slow clock before sleep
`timescale 1ns/10ps
module irq_flag_unit
  import irq_flag_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic ce, // clock enable, freezes state when low
  irq_link_if.device link, // CPU side
  input wire logic [PERIPH_GROUPS-1:0][3:0] periph_event, // event pulses
  input wire logic [7:0] clk_tap, // clock timer taps, 128 Hz at bit 0
  input wire logic nmi_src, // non-maskable event pulse
  output logic osc_low_stop, // low-speed oscillator stopped
  output logic osc_high_stop // high-speed oscillator stopped
);

  // ************************************************************
  // Declarations
  // ************************************************************

  logic [GROUPS-1:0][3:0] ev;
  logic [GROUPS-1:0][3:0] flag_w;
  logic [GROUPS-1:0][3:0] mask_w;
  logic [GROUPS-1:0][3:0] pend_w;
  logic [GROUPS-1:0] flag_hit;
  logic [GROUPS-1:0] mask_hit;
  logic [7:0] tap_q;
  logic [7:0] tap_fall;
  logic wr_stb;
  logic rd_stb;
  logic any_pend;
  logic key_pend;
  logic sp_ok;
  sp_state_t sp_q;
  sp_state_t sp_d;
  logic held_q;
  logic iflag_q;
  logic iflag_rise;
  logic nmi_pend_q;
  logic sleep_q;
  logic [3:0] rdata_d;
  logic [3:0] rdata_q;
  logic ack_q;

  assign wr_stb = link.sel && link.we;
  assign rd_stb = link.sel && !link.we;

  // ************************************************************
  // Event routing
  // ************************************************************

  // Taps come from the clock timer on this same clock, so they are
  // compared with last cycle's value without synchronisers.
  assign tap_fall = tap_q & ~clk_tap;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tap_q <= 8'h00;
    end else if (ce) begin
      tap_q <= clk_tap;
    end
  end

  always_comb begin
    for (int g = 0; g < PERIPH_GROUPS; g++) begin
      ev[g] = periph_event[g];
    end
    ev[G_FAST_CLK] = tap_fall[3:0];
    ev[G_SLOW_CLK] = tap_fall[7:4];
  end

  // ************************************************************
  // Flag and mask words
  // ************************************************************

  genvar gi;
  generate
    for (gi = 0; gi < GROUPS; gi++) begin : grp
      assign flag_hit[gi] = link.addr == FLAG_OFS[gi];
      assign mask_hit[gi] = link.addr == MASK_OFS[gi];
      irq_flag_group #(
        .IMPL(IMPL_BITS[gi])
      ) u_group (
        .hclk(hclk),
        .hresetn(hresetn),
        .ce(ce),
        .event_in(ev[gi]),
        .flag_wr(wr_stb && flag_hit[gi]),
        .mask_wr(wr_stb && mask_hit[gi]),
        .wdata(link.wdata),
        .flag_q(flag_w[gi]),
        .mask_q(mask_w[gi]),
        .pend(pend_w[gi])
      );
    end
  endgenerate

  assign any_pend = |pend_w;
  assign key_pend = |pend_w[G_KEY0] || |pend_w[G_KEY1];

  // ************************************************************
  // Stack pointer pairing
  // ************************************************************

  // A single pointer write reopens the pair, so a half-set stack
  // never lets a request through.
  always_comb begin
    sp_d = sp_q;
    if (link.ptr1_wr && link.ptr2_wr) begin
      sp_d = SP_BOTH;
    end else if (link.ptr1_wr) begin
      case (sp_q)
        SP_SECOND: sp_d = SP_BOTH;
        default: sp_d = SP_FIRST;
      endcase
    end else if (link.ptr2_wr) begin
      case (sp_q)
        SP_FIRST: sp_d = SP_BOTH;
        default: sp_d = SP_SECOND;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sp_q <= SP_NONE;
    end else if (ce) begin
      sp_q <= sp_d;
    end
  end

  assign sp_ok = sp_q == SP_BOTH;

  // ************************************************************
  // Request hold-off after a taken interrupt
  // ************************************************************

  assign iflag_rise = link.iflag && !iflag_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      iflag_q <= 1'b0;
    end else if (ce) begin
      iflag_q <= link.iflag;
    end
  end

  // The CPU clears its own enable on entry; the request comes back
  // when that enable rises again or the handler returns.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 1'b0;
    end else if (ce) begin
      if (link.int_ack) begin
        held_q <= 1'b1;
      end else if (iflag_rise || link.int_return) begin
        held_q <= 1'b0;
      end
    end
  end

  assign link.irq_req = any_pend && sp_ok && !held_q;

  // ************************************************************
  // Non-maskable request
  // ************************************************************

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nmi_pend_q <= 1'b0;
    end else if (ce) begin
      nmi_pend_q <= nmi_src || (nmi_pend_q && !link.nmi_ack);
    end
  end

  assign link.nmi_req = nmi_pend_q && sp_ok;

  // ************************************************************
  // Sleep
  // ************************************************************

  // Only an enabled key flag can wake the part, since every other
  // source is clocked by the stopped oscillators.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sleep_q <= 1'b0;
    end else if (ce) begin
      if (link.sleep) begin
        sleep_q <= 1'b1;
      end else if (key_pend) begin
        sleep_q <= 1'b0;
      end
    end
  end

  assign osc_low_stop = sleep_q;
  assign osc_high_stop = sleep_q;

  // ************************************************************
  // Register reads
  // ************************************************************

  always_comb begin
    rdata_d = 4'h0;
    for (int g = 0; g < GROUPS; g++) begin
      if (flag_hit[g]) begin
        rdata_d = flag_w[g];
      end
      if (mask_hit[g]) begin
        rdata_d = mask_w[g];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rdata_q <= 4'h0;
    end else if (ce && rd_stb) begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ack_q <= 1'b0;
    end else if (ce) begin
      ack_q <= link.sel;
    end
  end

  assign link.rdata = rdata_q;
  assign link.ack = ack_q;

endmodule

// >>> irq_link_assertions.sv
// Concurrent checks on the link between the two ends of the unit.
`timescale 1ns/10ps
module irq_link_assertions
  import irq_flag_pkg::*;
(
  input wire logic hclk, // system clock
  input wire logic hresetn, // asynchronous reset, active low
  input wire logic sel, // access strobe
  input wire logic we, // write when high
  input wire logic [15:0] addr, // word address
  input wire logic [3:0] wdata, // write data
  input wire logic [3:0] rdata, // read data
  input wire logic ack, // access answered
  input wire logic ptr1_wr, // first stack pointer written
  input wire logic ptr2_wr, // second stack pointer written
  input wire logic int_ack, // maskable request taken
  input wire logic irq_req, // maskable request
  input wire logic nmi_req // non-maskable request
);
  // ****************************************************************
  // Helper logic
  // ****************************************************************
  logic ptr1_q;
  logic ptr2_q;
  logic open_w;
  logic [3:0] rd_exp_q;
  logic [3:0] mask_m [GROUPS];

  function automatic int gidx(logic [15:0] a, bit fl);
    gidx = -1;
    for (int i = 0; i < GROUPS; i++) begin
      if ((fl ? FLAG_OFS[i] : MASK_OFS[i]) == a) gidx = i;
    end
  endfunction

  // A lone pointer write after the pair was complete closes the gate again.
  assign open_w = ptr1_q & ptr2_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ptr1_q <= 1'b0;
      ptr2_q <= 1'b0;
    end else begin
      ptr1_q <= ptr1_wr | (ptr1_q & ~(ptr2_wr & open_w));
      ptr2_q <= ptr2_wr | (ptr2_q & ~(ptr1_wr & open_w));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < GROUPS; i++) mask_m[i] <= MASK_RST;
      rd_exp_q <= 4'h0;
    end else if (sel && gidx(addr, 1'b0) >= 0) begin
      if (we) mask_m[gidx(addr, 1'b0)] <= wdata & IMPL_BITS[gidx(addr, 1'b0)];
      rd_exp_q <= mask_m[gidx(addr, 1'b0)];
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence mask_rd;
    sel && !we && gidx(addr, 1'b0) >= 0;
  endsequence
  sequence hole_rd;
    sel && !we && gidx(addr, 1'b0) < 0 && gidx(addr, 1'b1) < 0;
  endsequence

  a_ack_follows_sel: assert property (sel |=> ack)
    else $error("access not answered one cycle later");
  a_ack_has_cause: assert property (ack |-> $past(sel))
    else $error("answer without an access");
  a_mask_readback: assert property (mask_rd |=> rdata == rd_exp_q)
    else $error("mask word read differs from stored value");
  a_hole_reads_zero: assert property (hole_rd |=> rdata == 4'h0)
    else $error("unmapped word did not read zero");
  a_rdata_holds: assert property (!(sel && !we) |=> $stable(rdata))
    else $error("read data moved without a read");
  a_irq_needs_pointers: assert property (!open_w |-> !irq_req)
    else $error("maskable request while pointers unset");
  a_nmi_needs_pointers: assert property (!open_w |-> !nmi_req)
    else $error("non-maskable request while pointers unset");
  a_taken_request_held: assert property (int_ack |=> !irq_req)
    else $error("request stayed up after being taken");
endmodule

// >>> irq_link_if.sv
// Link between the interrupt unit and the CPU-side controller.
`timescale 1ns/10ps
interface irq_link_if;
  logic sel;
  logic we;
  logic [15:0] addr;
  logic [3:0] wdata;
  logic [3:0] rdata;
  logic ack;
  logic iflag;
  logic int_return;
  logic ptr1_wr;
  logic ptr2_wr;
  logic int_ack;
  logic nmi_ack;
  logic sleep;
  logic irq_req;
  logic nmi_req;
  modport device (
    input sel, we, addr, wdata, iflag, int_return, ptr1_wr, ptr2_wr,
    input int_ack, nmi_ack, sleep,
    output rdata, ack, irq_req, nmi_req
  );
  modport host (
    output sel, we, addr, wdata, iflag, int_return, ptr1_wr, ptr2_wr,
    output int_ack, nmi_ack, sleep,
    input rdata, ack, irq_req, nmi_req
  );
endinterface

// >>> test_irq_flag_unit.sv
// Self-checking bench for both ends of the unit joined by the link.
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin \
  $display("FAIL %s expected %h seen %h", nm, e, g); num_errors++; end end
module test_irq_flag_unit
  import irq_flag_pkg::*;
;
  typedef struct {string nm; logic [31:0] m; logic [31:0] v;} note_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_dp = 1'b0;
  logic nmi_src = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = 2'b00;
  logic [PERIPH_GROUPS-1:0][3:0] ev = '0;
  logic [7:0] tap = '0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic osc_lo;
  logic osc_hi;
  int num_errors = 0;
  int n_checks = 0;
  note_t notes[$];

  irq_link_if link();
  irq_flag_unit irq_flag_unit_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .link(link.device), .periph_event(ev), .clk_tap(tap),
    .nmi_src(nmi_src), .osc_low_stop(osc_lo), .osc_high_stop(osc_hi));
  irq_cpu_ctrl irq_cpu_ctrl_i (.hclk(hclk), .hresetn(hresetn), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .link(link.host));
  irq_link_assertions irq_link_assertions_i (.hclk(hclk),
    .hresetn(hresetn), .sel(link.sel), .we(link.we), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack),
    .ptr1_wr(link.ptr1_wr), .ptr2_wr(link.ptr2_wr), .int_ack(link.int_ack),
    .irq_req(link.irq_req), .nmi_req(link.nmi_req));

  always #25 hclk = ~hclk;

  // ****************************************************************
  // Bus tasks
  // ****************************************************************
  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge hclk); while (hready !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  function automatic logic [31:0] cmd(logic [15:0] a, logic [3:0] d);
    cmd = 32'(a) | (32'(d) << CMD_DATA_LSB) | (32'h1 << CMD_WRITE_BIT);
  endfunction

  task automatic want(input string nm, input logic [31:0] m, v);
    notes.push_back('{nm, m, v});
  endtask

  task automatic lwr(input logic [15:0] a, input logic [3:0] d);
    bus(HOST_CMD_OFS, 1'b1, cmd(a, d));
    repeat (2) @(posedge hclk);
  endtask

  // The command is done two cycles after its data phase.
  task automatic lrd(input string nm, input logic [15:0] a,
                     input logic [3:0] e);
    bus(HOST_CMD_OFS, 1'b1, 32'(a));
    repeat (2) @(posedge hclk);
    want(nm, 32'h0000_00f1, 32'(e) << STAT_RDATA_LSB);
    bus(HOST_STAT_OFS, 1'b0, '0);
  endtask

  task automatic req(input string nm, input logic i, n);
    want(nm, 32'h0000_0300, {22'h0, n, i, 8'h00});
    bus(HOST_STAT_OFS, 1'b0, '0);
  endtask

  task automatic ctrl(input logic [31:0] v);
    bus(HOST_CTRL_OFS, 1'b1, v);
    repeat (3) @(posedge hclk);
  endtask

  task automatic pulse(input int g, b);
    ev[g][b] <= 1'b1;
    @(posedge hclk);
    ev <= '0;
    repeat (3) @(posedge hclk);
  endtask

  task automatic close_out;
    $display("errors %0d checks %0d", num_errors, n_checks);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge hclk) begin
    if (rd_dp && hready === 1'b1 && notes.size() > 0) begin
      `CHK("hresp", 1'b0, hresp)
      `CHK(notes[0].nm, notes[0].v, hrdata & notes[0].m)
      void'(notes.pop_front());
    end
  end

  initial begin
    repeat (30000) @(posedge hclk);
    num_errors++;
    close_out();
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [3:0] r;
    int g;
    void'($urandom(91913));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < GROUPS; i++) begin
      lrd("mask", MASK_OFS[i], MASK_RST);
      lrd("flag", FLAG_OFS[i], FLAG_RST);
      r = 4'($urandom);
      lwr(MASK_OFS[i], r);
      lrd("mask", MASK_OFS[i], r & IMPL_BITS[i]);
    end
    lrd("unmapped", 16'hfff0, 4'h0);
    // Masks are random here, so flags must set whatever the mask holds.
    for (int i = 0; i < PERIPH_GROUPS; i++) begin
      for (int b = 0; b < 4; b++) begin
        pulse(i, b);
        lwr(FLAG_OFS[i], 4'h0);
        r = IMPL_BITS[i] & (4'h1 << b);
        lrd("flag", FLAG_OFS[i], r);
        lwr(FLAG_OFS[i], 4'hf);
        lrd("flag", FLAG_OFS[i], 4'h0);
      end
      lwr(MASK_OFS[i], 4'h0);
    end
    tap <= 8'hff;
    repeat (3) @(posedge hclk);
    lrd("tap rise", FLAG_OFS[G_FAST_CLK], 4'h0);
    for (int k = 0; k < 8; k++) begin
      tap <= 8'hff ^ (8'h01 << k);
      repeat (3) @(posedge hclk);
      tap <= 8'hff;
      g = k < 4 ? G_FAST_CLK : G_SLOW_CLK;
      lrd("tap fall", FLAG_OFS[g], 4'h1 << (k % 4));
      lwr(FLAG_OFS[g], 4'hf);
    end
    lwr(MASK_OFS[5], 4'h1);
    pulse(5, 0);
    nmi_src <= 1'b1;
    @(posedge hclk);
    nmi_src <= 1'b0;
    ctrl(32'h1);
    req("no pointers", 1'b0, 1'b0);
    ctrl(32'h5);
    req("one pointer", 1'b0, 1'b0);
    ctrl(32'h9);
    req("pointers set", 1'b1, 1'b1);
    ctrl(32'h21);
    req("nmi taken", 1'b1, 1'b0);
    lwr(MASK_OFS[5], 4'h0);
    req("masked", 1'b0, 1'b0);
    lwr(MASK_OFS[5], 4'h1);
    ctrl(32'h11);
    req("held", 1'b0, 1'b0);
    ctrl(32'h3);
    req("after return", 1'b1, 1'b0);
    ctrl(32'h11);
    ctrl(32'h0);
    ctrl(32'h1);
    req("after enable", 1'b1, 1'b0);
    ctrl(32'h5);
    req("lone pointer", 1'b0, 1'b0);
    ctrl(32'h9);
    req("pair again", 1'b1, 1'b0);
    // The clear reaches the link on the same edge as the new event.
    bus(HOST_CMD_OFS, 1'b1, cmd(FLAG_OFS[5], 4'h1));
    ev[5][0] <= 1'b1;
    @(posedge hclk);
    ev <= '0;
    repeat (2) @(posedge hclk);
    lrd("event wins", FLAG_OFS[5], 4'h1);
    lwr(FLAG_OFS[5], 4'h1);
    req("handler clear", 1'b0, 1'b0);
    lwr(MASK_OFS[G_KEY0], 4'h1);
    ctrl(32'h41);
    `CHK("osc stop", 2'b11, {osc_lo, osc_hi})
    pulse(G_KEY0, 0);
    `CHK("osc wake", 2'b00, {osc_lo, osc_hi})
    close_out();
  end
endmodule
